// ===== common/fidq_pkg.sv
package fidq_pkg;
  // Bus geometry
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  // Command addresses and codes
  localparam logic [19:0] ADR_UNLOCK1 = 20'h05555;
  localparam logic [19:0] ADR_UNLOCK2 = 20'h02aaa;
  localparam logic [19:0] ADR_SHORT_QUERY = 20'h00055;
  localparam logic [19:0] ADR_ANY = 20'h00000;
  localparam logic [15:0] DAT_UNLOCK1 = 16'h00aa;
  localparam logic [15:0] DAT_UNLOCK2 = 16'h0055;
  localparam logic [15:0] CMD_QUERY = 16'h0098;
  localparam logic [15:0] CMD_PROD_ID = 16'h0090;
  localparam logic [15:0] CMD_SECURITY = 16'h0088;
  localparam logic [15:0] CMD_EXIT = 16'h00f0;
  // Identification read addresses
  localparam logic [19:0] ADR_MANUF_ID = 20'h00000;
  localparam logic [19:0] ADR_DEVICE_ID = 20'h00001;
  localparam logic [19:0] ADR_SEC_FACTORY = 20'h00000;
  localparam logic [19:0] ADR_SEC_USER = 20'h00008;
  // Timing at 100 MHz
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_SETUP_NS = 30;
  localparam int T_STROBE_NS = 40;
  localparam int T_ACCESS_NS = 70;
  localparam int T_HOLD_NS = 20;
  localparam int T_RESET_NS = 1000;
  localparam int T_RECOVER_NS = 1000;
  localparam int CYC_SETUP = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_STROBE = (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_ACCESS = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 2;
  localparam int CYC_HOLD = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_RESET = (T_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_RECOVER = (T_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;
  // Host operations
  typedef enum logic [3:0] {
    OP_READ,
    OP_WRITE,
    OP_ENTER_QUERY,
    OP_ENTER_QUERY_SHORT,
    OP_ENTER_PROD_ID,
    OP_ENTER_SECURITY,
    OP_EXIT,
    OP_EXIT_SHORT,
    OP_HW_RESET
  } fidq_op_t;
  // Device mode as tracked by the host
  typedef enum logic [1:0] {
    MODE_ARRAY,
    MODE_QUERY,
    MODE_PROD_ID,
    MODE_SECURITY
  } fidq_mode_t;
endpackage

// ===== src/fidq_host.sv
module fidq_host
  import fidq_pkg::*;
#(
  parameter int AW = ADDR_W,
  parameter int DW = DATA_W
)
(
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RESET,
  // Request side
  input wire logic REQ_VALID,
  input wire fidq_op_t REQ_OP,
  input wire logic [AW-1:0] REQ_ADDR,
  input wire logic [DW-1:0] REQ_WDATA,
  output logic REQ_READY,
  output logic RSP_VALID,
  output logic [DW-1:0] RSP_RDATA,
  output fidq_mode_t MODE,
  // Flash pins
  output logic [AW-1:0] FL_ADDR,
  input wire logic [DW-1:0] FL_DQ_IN,
  output logic [DW-1:0] FL_DQ_OUT,
  output logic FL_DQ_OE,
  output logic FL_CE_N,
  output logic FL_OE_N,
  output logic FL_WE_N,
  output logic FL_RST_N
);

  // Command words are fixed at 20/16 bits, and the counter must reach the reset times
  if (AW != ADDR_W || DW != DATA_W || CYC_RESET >= (1 << CNT_W) || CYC_RECOVER >= (1 << CNT_W))
  begin : g_bad_params
    $error("fidq_host: unsupported bus width or counter range");
  end

  typedef enum {
    ST_IDLE,
    ST_SETUP,
    ST_STROBE,
    ST_HOLD,
    ST_READ_WAIT,
    ST_RST_LOW,
    ST_RST_RECOVER
  } fidq_state_t;

  fidq_state_t state_q;
  fidq_op_t op_q;
  logic [1:0] step_q;
  logic [1:0] nsteps_q;
  logic [CNT_W-1:0] cnt_q;
  logic [AW-1:0] addr_q;
  logic [DW-1:0] wdata_q;
  logic [DW-1:0] dq_s1_q;
  logic [DW-1:0] dq_s2_q;

  // Number of bus writes an operation needs, minus one
  function automatic logic [1:0] op_steps(input fidq_op_t op);
    case (op)
      OP_ENTER_QUERY, OP_ENTER_PROD_ID, OP_ENTER_SECURITY, OP_EXIT: op_steps = 2'd2;
      default: op_steps = 2'd0;
    endcase
  endfunction

  // Command code for the last write of a sequence
  function automatic logic [DW-1:0] op_code(input fidq_op_t op);
    case (op)
      OP_ENTER_QUERY, OP_ENTER_QUERY_SHORT: op_code = CMD_QUERY;
      OP_ENTER_PROD_ID: op_code = CMD_PROD_ID;
      OP_ENTER_SECURITY: op_code = CMD_SECURITY;
      default: op_code = CMD_EXIT;
    endcase
  endfunction

  // Address and data of one step of an unlock sequence
  function automatic logic [AW+DW-1:0] step_word(input fidq_op_t op, input logic [1:0] step,
                                                 input logic [AW-1:0] a, input logic [DW-1:0] d);
    logic [AW-1:0] sa;
    logic [DW-1:0] sd;
    sa = ADR_UNLOCK1;
    sd = DAT_UNLOCK1;
    case (op)
      OP_WRITE:
      begin
        sa = a;
        sd = d;
      end
      OP_ENTER_QUERY_SHORT:
      begin
        sa = ADR_SHORT_QUERY;
        sd = CMD_QUERY;
      end
      OP_EXIT_SHORT:
      begin
        sa = ADR_ANY;
        sd = CMD_EXIT;
      end
      default:
      begin
        if (step == 2'd1)
        begin
          sa = ADR_UNLOCK2;
          sd = DAT_UNLOCK2;
        end
        else if (step == 2'd2)
        begin
          sa = ADR_UNLOCK1;
          sd = op_code(op);
        end
      end
    endcase
    step_word = {sa, sd};
  endfunction

  // Pin inputs pass two flip-flops before use
  always_ff @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
    begin
      dq_s1_q <= '0;
      dq_s2_q <= '0;
    end
    else
    begin
      dq_s1_q <= FL_DQ_IN;
      dq_s2_q <= dq_s1_q;
    end
  end

  // Bus cycle sequencer
  always_ff @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
    begin
      state_q <= ST_IDLE;
      op_q <= OP_READ;
      step_q <= 2'd0;
      nsteps_q <= 2'd0;
      cnt_q <= '0;
      addr_q <= '0;
      wdata_q <= '0;
      REQ_READY <= 1'b0;
      RSP_VALID <= 1'b0;
      RSP_RDATA <= '0;
      FL_ADDR <= '0;
      FL_DQ_OUT <= '0;
      FL_DQ_OE <= 1'b0;
      FL_CE_N <= 1'b1;
      FL_OE_N <= 1'b1;
      FL_WE_N <= 1'b1;
      FL_RST_N <= 1'b1;
    end
    else
    begin
      RSP_VALID <= 1'b0;
      case (state_q)
        ST_IDLE:
        begin
          REQ_READY <= 1'b1;
          FL_CE_N <= 1'b1;
          FL_OE_N <= 1'b1;
          FL_WE_N <= 1'b1;
          FL_DQ_OE <= 1'b0;
          if (REQ_VALID && REQ_READY)
          begin
            REQ_READY <= 1'b0;
            op_q <= REQ_OP;
            addr_q <= REQ_ADDR;
            wdata_q <= REQ_WDATA;
            step_q <= 2'd0;
            nsteps_q <= op_steps(REQ_OP);
            cnt_q <= '0;
            if (REQ_OP == OP_HW_RESET)
            begin
              FL_RST_N <= 1'b0;
              state_q <= ST_RST_LOW;
            end
            else if (REQ_OP == OP_READ)
            begin
              FL_ADDR <= REQ_ADDR;
              FL_CE_N <= 1'b0;
              FL_OE_N <= 1'b0;
              state_q <= ST_READ_WAIT;
            end
            else
            begin
              {FL_ADDR, FL_DQ_OUT} <= step_word(REQ_OP, 2'd0, REQ_ADDR, REQ_WDATA);
              FL_CE_N <= 1'b0;
              FL_DQ_OE <= 1'b1;
              state_q <= ST_SETUP;
            end
          end
        end
        ST_SETUP:
        begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == CNT_W'(CYC_SETUP - 1))
          begin
            cnt_q <= '0;
            FL_WE_N <= 1'b0;
            state_q <= ST_STROBE;
          end
        end
        ST_STROBE:
        begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == CNT_W'(CYC_STROBE - 1))
          begin
            cnt_q <= '0;
            FL_WE_N <= 1'b1;
            state_q <= ST_HOLD;
          end
        end
        ST_HOLD:
        begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == CNT_W'(CYC_HOLD - 1))
          begin
            cnt_q <= '0;
            if (step_q == nsteps_q)
            begin
              FL_CE_N <= 1'b1;
              FL_DQ_OE <= 1'b0;
              RSP_VALID <= 1'b1;
              state_q <= ST_IDLE;
            end
            else
            begin
              // Whole sequence is issued back to back so no stray write breaks it
              step_q <= step_q + 2'd1;
              {FL_ADDR, FL_DQ_OUT} <= step_word(op_q, step_q + 2'd1, addr_q, wdata_q);
              state_q <= ST_SETUP;
            end
          end
        end
        ST_READ_WAIT:
        begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == CNT_W'(CYC_ACCESS - 1))
          begin
            RSP_RDATA <= dq_s2_q;
            RSP_VALID <= 1'b1;
            FL_CE_N <= 1'b1;
            FL_OE_N <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
        ST_RST_LOW:
        begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == CNT_W'(CYC_RESET - 1))
          begin
            cnt_q <= '0;
            FL_RST_N <= 1'b1;
            state_q <= ST_RST_RECOVER;
          end
        end
        ST_RST_RECOVER:
        begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == CNT_W'(CYC_RECOVER - 1))
          begin
            RSP_VALID <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
        default:
        begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Device mode tracking, updated when a sequence completes and set to array mode while a hardware reset recovers
  always_ff @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
    begin
      MODE <= MODE_ARRAY;
    end
    else if (state_q == ST_RST_RECOVER)
    begin
      MODE <= MODE_ARRAY;
    end
    else if (state_q == ST_HOLD && step_q == nsteps_q && cnt_q == CNT_W'(CYC_HOLD - 1))
    begin
      case (op_q)
        OP_ENTER_QUERY, OP_ENTER_QUERY_SHORT: MODE <= MODE_QUERY;
        OP_ENTER_PROD_ID: MODE <= MODE_PROD_ID;
        OP_ENTER_SECURITY: MODE <= MODE_SECURITY;
        // Exit is sent even from array mode to recover a confused device
        OP_EXIT, OP_EXIT_SHORT: MODE <= MODE_ARRAY;
        default: MODE <= MODE;
      endcase
    end
  end

endmodule // fidq_host

// ===== tb/fidq_chk.sv
module fidq_chk
  import fidq_pkg::*;
#(
  parameter int AW = ADDR_W,
  parameter int DW = DATA_W
)
(
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RESET,
  // Request side
  input wire logic REQ_VALID,
  input wire logic REQ_READY,
  input wire logic RSP_VALID,
  input wire fidq_op_t REQ_OP,
  input wire logic [AW-1:0] REQ_ADDR,
  input wire fidq_mode_t MODE,
  // Flash pins
  input wire logic [AW-1:0] FL_ADDR,
  input wire logic [DW-1:0] FL_DQ_OUT,
  input wire logic FL_DQ_OE,
  input wire logic FL_CE_N,
  input wire logic FL_OE_N,
  input wire logic FL_WE_N,
  input wire logic FL_RST_N
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  logic take;
  assign take = REQ_VALID && REQ_READY;
  property p_rd_pins;
    !FL_OE_N |-> FL_WE_N && !FL_CE_N && !FL_DQ_OE;
  endproperty
  a_rd_pins: assert property (p_rd_pins) else $error("read pins");
  property p_wr_pins;
    !FL_WE_N |-> FL_OE_N && !FL_CE_N && FL_DQ_OE;
  endproperty
  a_wr_pins: assert property (p_wr_pins) else $error("write pins");
  property p_rd_start;
    take && REQ_OP == OP_READ |=> !FL_OE_N && FL_ADDR == $past(REQ_ADDR);
  endproperty
  a_rd_start: assert property (p_rd_start) else $error("read start");
  property p_rd_done;
    take && REQ_OP == OP_READ |-> ##[10:11] RSP_VALID;
  endproperty
  a_rd_done: assert property (p_rd_done) else $error("read done");
  property p_short;
    take && REQ_OP == OP_ENTER_QUERY_SHORT |-> ##[1:12] !FL_WE_N && FL_ADDR == ADR_SHORT_QUERY && FL_DQ_OUT == CMD_QUERY;
  endproperty
  a_short: assert property (p_short) else $error("short query");
  property p_query;
    take && REQ_OP == OP_ENTER_QUERY |-> ##[20:40] MODE == MODE_QUERY;
  endproperty
  a_query: assert property (p_query) else $error("query entry");
  property p_exit;
    take && (REQ_OP == OP_EXIT || REQ_OP == OP_EXIT_SHORT) |-> ##[8:40] MODE == MODE_ARRAY;
  endproperty
  a_exit: assert property (p_exit) else $error("exit");
  property p_hw_rst;
    take && REQ_OP == OP_HW_RESET |-> ##[1:4] !FL_RST_N [*8];
  endproperty
  a_hw_rst: assert property (p_hw_rst) else $error("flash reset");
endmodule // fidq_chk

bind fidq_host fidq_chk #(.AW(AW), .DW(DW)) i_chk (.CLK_SYS, .RESET, .REQ_VALID, .REQ_READY, .RSP_VALID, .REQ_OP,
  .REQ_ADDR, .MODE, .FL_ADDR, .FL_DQ_OUT, .FL_DQ_OE, .FL_CE_N, .FL_OE_N, .FL_WE_N, .FL_RST_N);

// ===== tb/fidq_flash_model.sv
module fidq_flash_model
  import fidq_pkg::*;
#(
  // Identification codes are arbitrary values
  parameter logic [15:0] MANUF_CODE = 16'h00c3,
  parameter logic [15:0] DEV_CODE = 16'h2a61
)
(
  // Bus pins
  input wire logic ce_n, oe_n, we_n, rst_n,
  input wire logic [19:0] addr,
  input wire logic [15:0] din,
  output logic [15:0] dout
);
  timeunit 1ns;
  timeprecision 1ps;
  fidq_mode_t mode_q = MODE_ARRAY;
  logic [1:0] step_q = 2'h0;
  logic [15:0] word_q;
  logic [15:0] data;
  logic [15:0] last = 16'h0;
  logic rd_en;
  logic a1;
  assign a1 = addr[14:0] == ADR_UNLOCK1[14:0];
  always @(posedge we_n or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_q <= MODE_ARRAY;
      step_q <= 2'h0;
    end
    else if (!ce_n && oe_n)
    begin
      word_q <= din;
      if (din[7:0] == CMD_EXIT[7:0])
      begin
        mode_q <= MODE_ARRAY;
        step_q <= 2'h0;
      end
      else if (step_q == 2'h0)
      begin
        step_q <= {1'b0, a1 && din[7:0] == DAT_UNLOCK1[7:0]};
        if (addr[14:0] == ADR_SHORT_QUERY[14:0] && din[7:0] == CMD_QUERY[7:0])
          mode_q <= MODE_QUERY;
      end
      else if (step_q == 2'h1)
        step_q <= (addr[14:0] == ADR_UNLOCK2[14:0] && din[7:0] == DAT_UNLOCK2[7:0]) ? 2'h2 : 2'h0;
      else
      begin
        step_q <= 2'h0;
        if (a1 && din[7:0] == CMD_QUERY[7:0])
          mode_q <= MODE_QUERY;
        if (a1 && din[7:0] == CMD_PROD_ID[7:0])
          mode_q <= MODE_PROD_ID;
        if (a1 && din[7:0] == CMD_SECURITY[7:0])
          mode_q <= MODE_SECURITY;
      end
    end
  end
  assign rd_en = !ce_n && !oe_n && we_n && rst_n;
  always_comb
    case (mode_q)
      MODE_QUERY: data = {8'h51, addr[7:0]};
      MODE_PROD_ID: data = addr[0] ? DEV_CODE : MANUF_CODE;
      MODE_SECURITY: data = {(addr[3] ? 8'hee : 8'hf0), 4'h0, addr[3:0]};
      default: data = addr[15:0] ^ 16'h5a3c;
    endcase
  // Released lines show the inverse of the last word, so stale data cannot pass
  always @*
    if (rd_en)
      last = data;
  assign dout = rd_en ? data : ~last;
endmodule // fidq_flash_model

// ===== tb/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import fidq_pkg::*;
  // Arbitrary identification values
  localparam logic [15:0] MANUF_CODE = 16'h00c3;
  localparam logic [15:0] DEV_CODE = 16'h2a61;
  localparam fidq_op_t ENT [4] = '{OP_ENTER_QUERY, OP_ENTER_QUERY_SHORT, OP_ENTER_PROD_ID, OP_ENTER_SECURITY};
  localparam fidq_mode_t MDS [4] = '{MODE_QUERY, MODE_QUERY, MODE_PROD_ID, MODE_SECURITY};
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic req_valid = 1'b0;
  fidq_op_t req_op = OP_READ;
  logic [19:0] req_addr = 20'h0;
  logic [15:0] req_wdata = 16'h0;
  logic req_ready, rsp_valid, fl_dq_oe, fl_ce_n, fl_oe_n, fl_we_n, fl_rst_n;
  logic [15:0] rsp_rdata, fl_dq_out, mem_dq, fl_dq_in;
  logic [19:0] fl_addr;
  fidq_mode_t mode;
  int num_errors = 0;
  int comparisons = 0;
  always #5 clk_sys = ~clk_sys;
  assign fl_dq_in = fl_dq_oe ? fl_dq_out : mem_dq;
  fidq_host i_dut (.CLK_SYS(clk_sys), .RESET(reset), .REQ_VALID(req_valid), .REQ_OP(req_op), .REQ_ADDR(req_addr),
    .REQ_WDATA(req_wdata), .REQ_READY(req_ready), .RSP_VALID(rsp_valid), .RSP_RDATA(rsp_rdata), .MODE(mode),
    .FL_ADDR(fl_addr), .FL_DQ_IN(fl_dq_in), .FL_DQ_OUT(fl_dq_out), .FL_DQ_OE(fl_dq_oe), .FL_CE_N(fl_ce_n),
    .FL_OE_N(fl_oe_n), .FL_WE_N(fl_we_n), .FL_RST_N(fl_rst_n));
  fidq_flash_model #(.MANUF_CODE(MANUF_CODE), .DEV_CODE(DEV_CODE)) i_mem (.ce_n(fl_ce_n), .oe_n(fl_oe_n),
    .we_n(fl_we_n), .rst_n(fl_rst_n), .addr(fl_addr), .din(fl_dq_out), .dout(mem_dq));
  task automatic wrap_up();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [15:0] exp_rd(input fidq_mode_t m, input logic [19:0] a);
    case (m)
      MODE_QUERY: return {8'h51, a[7:0]};
      MODE_PROD_ID: return a[0] ? DEV_CODE : MANUF_CODE;
      MODE_SECURITY: return {(a[3] ? 8'hee : 8'hf0), 4'h0, a[3:0]};
      default: return a[15:0] ^ 16'h5a3c;
    endcase
  endfunction
  // Called at a falling edge; the request is held until the edge that takes it
  task automatic do_op(input fidq_op_t op, input logic [19:0] a, input logic [15:0] d, output logic [15:0] rd);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 500)
    begin
      @(negedge clk_sys);
      n++;
    end
    req_op = op;
    req_addr = a;
    req_wdata = d;
    req_valid = 1'b1;
    @(negedge clk_sys);
    req_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 500)
    begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 500)
    begin
      num_errors++;
      wrap_up();
    end
    rd = rsp_rdata;
  endtask
  task automatic rd_chk(input fidq_mode_t m, input logic [19:0] a);
    logic [15:0] rd;
    do_op(OP_READ, a, 16'h0, rd);
    check("read data", rd, exp_rd(m, a));
  endtask
  initial
  begin
    logic [15:0] rd;
    void'($urandom(32'h268a));
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    reset = 1'b0;
    repeat (6) rd_chk(MODE_ARRAY, 20'($urandom));
    for (int k = 0; k < 4; k++)
    begin
      do_op(ENT[k], 20'h0, 16'h0, rd);
      check("mode", {14'h0, mode}, {14'h0, MDS[k]});
      rd_chk(MDS[k], 20'h0);
      rd_chk(MDS[k], 20'h1);
      repeat (4) rd_chk(MDS[k], {16'h0, 4'($urandom)});
      do_op(k[0] ? OP_EXIT_SHORT : OP_EXIT, 20'($urandom), 16'h0, rd);
      check("mode", {14'h0, mode}, {14'h0, MODE_ARRAY});
      rd_chk(MODE_ARRAY, 20'($urandom));
    end
    do_op(OP_WRITE, ADR_UNLOCK1, DAT_UNLOCK1, rd);
    do_op(OP_WRITE, 20'h01234, 16'h0077, rd);
    do_op(OP_WRITE, ADR_UNLOCK1, CMD_QUERY, rd);
    rd_chk(MODE_ARRAY, 20'h00010);
    do_op(OP_EXIT_SHORT, 20'h0, 16'h0, rd);
    rd_chk(MODE_ARRAY, 20'h00011);
    do_op(OP_ENTER_QUERY, 20'h0, 16'h0, rd);
    do_op(OP_HW_RESET, 20'h0, 16'h0, rd);
    rd_chk(MODE_ARRAY, 20'h00012);
    wrap_up();
  end
endmodule // tb
